// ==== gpcio_params.svh ====
/*
 * Register offsets, field positions and reset values of the two-port GPIO block.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef GPCIO_PARAMS_SVH
`define GPCIO_PARAMS_SVH

`define GPCIO_OFF_PA_PIN      4'h0
`define GPCIO_OFF_PA_LAT      4'h1
`define GPCIO_OFF_PA_DIR      4'h2
`define GPCIO_OFF_AN_LOW      4'h3
`define GPCIO_OFF_PB_PIN      4'h4
`define GPCIO_OFF_PB_LAT      4'h5
`define GPCIO_OFF_PB_DIR      4'h6
`define GPCIO_OFF_AN_HIGH     4'h7
`define GPCIO_OFF_INTERRUPT_CONTROL      4'h8
`define GPCIO_OFF_INTERRUPT_CONTROL_TWO     4'h9
`define GPCIO_OFF_OSC_MODE    4'hA

`define GPCIO_PA_UNIMPL_BIT   4
`define GPCIO_PA_AN_BIT       5
`define GPCIO_PA_CLK_BIT      6
`define GPCIO_PA_AN_SEL_BIT   4
`define GPCIO_CHG_FLAG_BIT    0
`define GPCIO_PU_EN_N_BIT     7
`define GPCIO_IOC_LO          4
`define GPCIO_IOC_HI          7
`define GPCIO_PB_AN_LO        0
`define GPCIO_PB_AN_HI        3

`define GPCIO_DIR_RESET       8'hFF
`define GPCIO_LAT_RESET       8'h00
`define GPCIO_AN_LOW_RESET    8'h00
`define GPCIO_AN_HIGH_RESET   8'h00
`define GPCIO_INTERRUPT_CONTROL_TWO_RESET   8'h80
`define GPCIO_PA_IMPL_MASK    8'hEF
`define GPCIO_AN_LOW_NARROW   8'h1F
`define GPCIO_DIV_LAST        2'h1
`define GPCIO_CLR_HOLD        1'h1

`endif

// ==== gpcio_pkg.sv ====
/*
 * Types of the two-port GPIO block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpcio_pkg;
	typedef enum logic [1:0] {
		GPCIO_OSC_HS,
		GPCIO_OSC_RC,
		GPCIO_OSC_EC,
		GPCIO_OSC_OTHER
	} gpcio_osc_t;
endpackage

// ==== gpcio_port.sv ====
/*
 * Two 8-bit GPIO ports with weak pull-ups on port B and change detection on port B<7:4>.
 * Assumes a simple register port with read data one cycle after the read strobe,
 * and pin inputs synchronous to clock. Analog pins read digital zero.
 */
// Summary of operation
// RULE_01 - Port B: eight pins, each in or out
// RULE_02 - Direction 1 tri-states, 0 drives latch
// RULE_03 - Latch reads return latch, not pins
// RULE_04 - Clearing INTERRUPT_CONTROL_TWO bit 7 enables pull-ups
// RULE_05 - Output pins never get pull-up
// RULE_06 - Pull-ups off after reset
// RULE_07 - Reset: B<3:0> analog zero, B<7:4> digital
// RULE_08 - Change detect on B<7:4> inputs only
// RULE_09 - Reference captured on port B read
// RULE_10 - Mismatches ORed into INTERRUPT_CONTROL bit 0
// RULE_11 - Mismatch keeps setting; clear after a cycle
// RULE_12 - Software: access port, wait, clear flag
// RULE_13 - Change event wakes from sleep, idle
// RULE_14 - Software avoids polling during change use
// RULE_15 - A5 digital input off while analog
// RULE_16 - A5 latch drives regardless of analog
// RULE_17 - RC/EC modes: A6 outputs clock/4
// RULE_18 - Port A bit 4 reads zero
// RULE_19 - Overriding function ignores direction bit
// RULE_20 - Upper analog bits only on large package
// RULE_21 - Software sets analog-high bit for digital
// RULE_22 - Pull-up needs enable, input, digital
`timescale 1ns/1ps
`include "gpcio_params.svh"

module gpcio_port #(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] port_a_in,
	output logic      [7:0] port_a_out,
	output logic      [7:0] port_a_oe,
	input  wire logic [7:0] port_b_in,
	output logic      [7:0] port_b_out,
	output logic      [7:0] port_b_oe,
	output logic      [7:0] port_b_pullup,
	output logic            port_change_flag,
	output logic            wake_request
);

	logic [7:0]             port_a_output_latch;
	logic [7:0]             port_a_direction;
	logic [7:0]             analog_select_low;
	logic [7:0]             port_b_output_latch;
	logic [7:0]             port_b_direction;
	logic [7:0]             analog_select_high;
	logic                   pullup_enable_n;
	gpcio_pkg::gpcio_osc_t  osc_mode;
	logic [3:0]             ioc_reference;
	logic [1:0]             clk_div;
	logic                   cycle_clock_out;
	logic                   clear_hold;

	localparam logic [7:0] INTERRUPT_CONTROL_TWO_RST = `GPCIO_INTERRUPT_CONTROL_TWO_RESET;

	// Decode
	wire wr_pa_pin  = reg_wr && reg_addr == `GPCIO_OFF_PA_PIN;
	wire wr_pa_lat  = reg_wr && reg_addr == `GPCIO_OFF_PA_LAT;
	wire wr_pa_dir  = reg_wr && reg_addr == `GPCIO_OFF_PA_DIR;
	wire wr_an_low  = reg_wr && reg_addr == `GPCIO_OFF_AN_LOW;
	wire wr_pb_pin  = reg_wr && reg_addr == `GPCIO_OFF_PB_PIN;
	wire wr_pb_lat  = reg_wr && reg_addr == `GPCIO_OFF_PB_LAT;
	wire wr_pb_dir  = reg_wr && reg_addr == `GPCIO_OFF_PB_DIR;
	wire wr_an_high = reg_wr && reg_addr == `GPCIO_OFF_AN_HIGH;
	wire wr_interrupt_control  = reg_wr && reg_addr == `GPCIO_OFF_INTERRUPT_CONTROL;
	wire wr_interrupt_control_two = reg_wr && reg_addr == `GPCIO_OFF_INTERRUPT_CONTROL_TWO;
	wire wr_osc     = reg_wr && reg_addr == `GPCIO_OFF_OSC_MODE;
	wire rd_pb_pin  = reg_rd && reg_addr == `GPCIO_OFF_PB_PIN;
	wire pb_access  = rd_pb_pin || wr_pb_pin;

	// Upper analog-select bits vanish on the small package
	wire [7:0] an_low_mask = LARGE_PACKAGE ? 8'hFF : `GPCIO_AN_LOW_NARROW; // [RULE_20]

	// Analog-select bit at 1 means digital (reset 0 = all analog)
	wire       pa5_analog = !analog_select_low[`GPCIO_PA_AN_SEL_BIT];
	wire [7:0] pb_analog;
	wire [7:0] pb_digital_in;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pb
			if (g <= `GPCIO_PB_AN_HI) begin : g_an
				assign pb_analog[g] = !analog_select_high[g]; // [RULE_07]
			end else begin : g_dig
				assign pb_analog[g] = 1'b0; // [RULE_07]
			end
			assign pb_digital_in[g] = pb_analog[g] ? 1'b0 : port_b_in[g];
		end
	endgenerate

	// Port A input path
	wire cycle_clock_out_mode = osc_mode == gpcio_pkg::GPCIO_OSC_RC || osc_mode == gpcio_pkg::GPCIO_OSC_EC;
	wire [7:0] pa_read_raw = port_a_in & `GPCIO_PA_IMPL_MASK; // [RULE_18]
	wire [7:0] pa_read = pa5_analog ? (pa_read_raw & ~(8'h01 << `GPCIO_PA_AN_BIT)) // [RULE_15]
	                                : pa_read_raw;

	// Change detect, outputs excluded
	wire [3:0] ioc_inputs = port_b_direction[`GPCIO_IOC_HI:`GPCIO_IOC_LO];
	wire [3:0] ioc_now    = pb_digital_in[`GPCIO_IOC_HI:`GPCIO_IOC_LO];
	wire [3:0] mismatch   = (ioc_now ^ ioc_reference) & ioc_inputs; // [RULE_08]
	wire       any_mismatch = |mismatch; // [RULE_10]

	// Clearing only takes when no mismatch and the hold cycle passed
	wire flag_clear = wr_interrupt_control && !reg_wdata[`GPCIO_CHG_FLAG_BIT] && !clear_hold;
	wire next_flag  = any_mismatch ? 1'b1 : // [RULE_11]
	                  flag_clear   ? 1'b0 :
	                  wr_interrupt_control    ? (port_change_flag | reg_wdata[`GPCIO_CHG_FLAG_BIT])
	                               : port_change_flag;

	// Pull-ups
	wire [7:0] next_pullup = {8{!pullup_enable_n}} & port_b_direction & ~pb_analog; // [RULE_04] [RULE_05] [RULE_22]

	// Pin drive
	wire [7:0] next_pa_oe;
	wire [7:0] next_pa_out;
	// Unimplemented bit 4 must never drive the pin
	wire [7:0] pa_drive = ~port_a_direction & `GPCIO_PA_IMPL_MASK; // [RULE_18]
	assign next_pa_oe  = cycle_clock_out_mode ? (pa_drive | (8'h01 << `GPCIO_PA_CLK_BIT)) // [RULE_17]
	                               : pa_drive; // [RULE_02] [RULE_16]
	assign next_pa_out = cycle_clock_out_mode ? ((port_a_output_latch & ~(8'h01 << `GPCIO_PA_CLK_BIT))
	                                  | ({7'h00, cycle_clock_out} << `GPCIO_PA_CLK_BIT)) // [RULE_19]
	                               : port_a_output_latch;

	// Read mux
	logic [7:0] next_rdata;
	always_comb begin
		unique case (reg_addr)
			`GPCIO_OFF_PA_PIN:   next_rdata = pa_read;
			`GPCIO_OFF_PA_LAT:   next_rdata = port_a_output_latch; // [RULE_03]
			`GPCIO_OFF_PA_DIR:   next_rdata = port_a_direction;
			`GPCIO_OFF_AN_LOW:   next_rdata = analog_select_low;
			`GPCIO_OFF_PB_PIN:   next_rdata = pb_digital_in; // [RULE_07]
			`GPCIO_OFF_PB_LAT:   next_rdata = port_b_output_latch; // [RULE_03]
			`GPCIO_OFF_PB_DIR:   next_rdata = port_b_direction;
			`GPCIO_OFF_AN_HIGH:  next_rdata = analog_select_high;
			`GPCIO_OFF_INTERRUPT_CONTROL:   next_rdata = {7'h00, port_change_flag};
			`GPCIO_OFF_INTERRUPT_CONTROL_TWO:  next_rdata = {pullup_enable_n, 7'h00};
			`GPCIO_OFF_OSC_MODE: next_rdata = {6'h00, osc_mode};
			default:             next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port_a_output_latch <= `GPCIO_LAT_RESET;
			port_a_direction    <= `GPCIO_DIR_RESET & `GPCIO_PA_IMPL_MASK; // [RULE_18]
			analog_select_low   <= `GPCIO_AN_LOW_RESET;
			port_b_output_latch <= `GPCIO_LAT_RESET;
			port_b_direction    <= `GPCIO_DIR_RESET;
			analog_select_high  <= `GPCIO_AN_HIGH_RESET;
		end else begin
			if (wr_pa_pin || wr_pa_lat) begin
				port_a_output_latch <= reg_wdata & `GPCIO_PA_IMPL_MASK; // [RULE_18]
			end
			if (wr_pa_dir) begin
				port_a_direction <= reg_wdata & `GPCIO_PA_IMPL_MASK; // [RULE_18]
			end
			if (wr_an_low) begin
				analog_select_low <= reg_wdata & an_low_mask; // [RULE_20]
			end
			if (wr_pb_pin || wr_pb_lat) begin
				port_b_output_latch <= reg_wdata; // [RULE_01]
			end
			if (wr_pb_dir) begin
				port_b_direction <= reg_wdata; // [RULE_01]
			end
			if (wr_an_high) begin
				analog_select_high <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pullup_enable_n <= INTERRUPT_CONTROL_TWO_RST[`GPCIO_PU_EN_N_BIT]; // [RULE_06]
			osc_mode        <= gpcio_pkg::GPCIO_OSC_HS;
			ioc_reference   <= 4'h0;
			port_change_flag <= 1'b0;
			clear_hold      <= 1'b0;
		end else begin
			if (wr_interrupt_control_two) begin
				pullup_enable_n <= reg_wdata[`GPCIO_PU_EN_N_BIT]; // [RULE_04]
			end
			if (wr_osc) begin
				osc_mode <= gpcio_pkg::gpcio_osc_t'(reg_wdata[1:0]);
			end
			if (rd_pb_pin) begin
				ioc_reference <= ioc_now; // [RULE_09]
			end
			port_change_flag <= next_flag; // [RULE_10]
			clear_hold <= pb_access ? `GPCIO_CLR_HOLD : 1'b0; // [RULE_11]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk_div         <= 2'h0;
			cycle_clock_out <= 1'b0;
		end else begin
			clk_div <= clk_div + 2'h1;
			if (clk_div == `GPCIO_DIV_LAST || clk_div == 2'h3) begin
				cycle_clock_out <= !cycle_clock_out; // [RULE_17]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata     <= 8'h00;
			port_a_out    <= `GPCIO_LAT_RESET;
			port_a_oe     <= 8'h00;
			port_b_out    <= `GPCIO_LAT_RESET;
			port_b_oe     <= 8'h00;
			port_b_pullup <= 8'h00;
			wake_request  <= 1'b0;
		end else begin
			reg_rdata     <= reg_rd ? next_rdata : 8'h00;
			port_a_out    <= next_pa_out;
			port_a_oe     <= next_pa_oe;
			port_b_out    <= port_b_output_latch;
			port_b_oe     <= ~port_b_direction; // [RULE_02]
			port_b_pullup <= next_pullup;
			wake_request  <= next_flag; // [RULE_13]
		end
	end

	AST_FLAG_SET: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
		any_mismatch |=> port_change_flag)
		else $error("mismatch did not set change flag");
	AST_FLAG_STAYS: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
		(any_mismatch && wr_interrupt_control) |=> port_change_flag)
		else $error("flag cleared during mismatch");
	AST_OUT_EXCLUDED: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_08]
		(port_b_direction[`GPCIO_IOC_HI:`GPCIO_IOC_LO] == 4'h0) |-> !any_mismatch)
		else $error("output pin took part in change compare");
	AST_REF_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_09]
		rd_pb_pin |=> ioc_reference == $past(ioc_now))
		else $error("reference not captured on read");
	AST_PULLUP_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_05]
		##1 (port_b_pullup & port_b_oe) == 8'h00)
		else $error("pull-up on driven pin");
	AST_PULLUP_GLOBAL: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
		pullup_enable_n |=> port_b_pullup == 8'h00)
		else $error("pull-up active while disabled");
	AST_LAT_READ: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_03]
		(reg_rd && reg_addr == `GPCIO_OFF_PB_LAT) |=> reg_rdata == $past(port_b_output_latch))
		else $error("latch read returned wrong value");
	AST_PA_BIT4: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_18]
		(reg_rd && reg_addr <= `GPCIO_OFF_PA_DIR) |=> reg_rdata[`GPCIO_PA_UNIMPL_BIT] == 1'b0)
		else $error("port A bit 4 read non-zero");
	AST_DRIVE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
		##1 port_b_oe == ~$past(port_b_direction) && port_b_out == $past(port_b_output_latch))
		else $error("port B drive mismatch");
	AST_CYCLE_CLOCK_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_17]
		cycle_clock_out_mode |=> port_a_oe[`GPCIO_PA_CLK_BIT])
		else $error("clock out not driven");

	// Change flag clearing and the hold cycle
	AST_CLEAR_TAKES: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
		(flag_clear && !any_mismatch) |=> !port_change_flag)
		else $error("flag clear ignored");

	AST_HOLD_BLOCKS: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
		(wr_interrupt_control && clear_hold && port_change_flag) |=> port_change_flag)
		else $error("flag cleared inside hold cycle");

	AST_HOLD_ENDS: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
		(clear_hold && !pb_access) |=> !clear_hold)
		else $error("hold cycle did not end");

	AST_WAKE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_13]
		wake_request == port_change_flag)
		else $error("wake request differs from flag");

	AST_REF_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_09]
		!rd_pb_pin |=> $stable(ioc_reference))
		else $error("reference moved without read");

	AST_FLAG_READ: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
		(reg_rd && reg_addr == `GPCIO_OFF_INTERRUPT_CONTROL) |=> reg_rdata[0] == $past(port_change_flag))
		else $error("flag read wrong");

	// Port B reads and pull-ups
	AST_PB_READ: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_01]
		(reg_rd && reg_addr == `GPCIO_OFF_PB_PIN) |=> reg_rdata == $past(pb_digital_in))
		else $error("port B pin read wrong");

	AST_PB_ANALOG_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_07]
		(rd_pb_pin && analog_select_high[3:0] == 4'h0) |=> reg_rdata[3:0] == 4'h0)
		else $error("analog pins read non-zero");

	AST_PU_READ: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
		(reg_rd && reg_addr == `GPCIO_OFF_INTERRUPT_CONTROL_TWO) |=> reg_rdata[7] == $past(pullup_enable_n))
		else $error("pull-up control read wrong");

	AST_PULLUP_ANALOG: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_22]
		##1 (port_b_pullup & $past(pb_analog)) == 8'h00)
		else $error("pull-up on analog pin");

	AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_03]
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");

	// Port A paths
	AST_PA_LAT_READ: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_03]
		(reg_rd && reg_addr == `GPCIO_OFF_PA_LAT) |=> reg_rdata == $past(port_a_output_latch))
		else $error("port A latch read wrong");

	AST_PA5_ANALOG: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_15]
		(reg_rd && reg_addr == `GPCIO_OFF_PA_PIN && pa5_analog) |=> !reg_rdata[5])
		else $error("analog A5 read as digital");

	AST_PA5_DRIVE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_16]
		##1 port_a_out[5] == $past(port_a_output_latch[5]))
		else $error("A5 latch not driven");

	AST_PA_OE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
		!cycle_clock_out_mode |=> port_a_oe == $past(~port_a_direction & `GPCIO_PA_IMPL_MASK))
		else $error("port A enable wrong");

	AST_PA_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
		!cycle_clock_out_mode |=> port_a_out == $past(port_a_output_latch))
		else $error("port A drive wrong");

	AST_PA_OE_BIT4: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_18]
		!port_a_oe[`GPCIO_PA_UNIMPL_BIT])
		else $error("unimplemented bit driven");

	AST_CYCLE_CLOCK_OUT_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_17]
		cycle_clock_out_mode |=> port_a_out[`GPCIO_PA_CLK_BIT] == $past(cycle_clock_out))
		else $error("clock out value wrong");

	AST_HS_NO_CYCLE_CLOCK_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_19]
		(!cycle_clock_out_mode && port_a_direction[`GPCIO_PA_CLK_BIT]) |=> !port_a_oe[`GPCIO_PA_CLK_BIT])
		else $error("A6 driven as input");

	AST_AN_LOW_MASK: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_20]
		(analog_select_low & ~an_low_mask) == 8'h00)
		else $error("absent analog bits set");

	COV_CHANGE: cover property (@(posedge clock) disable iff (!rst_n)
		!port_change_flag ##1 port_change_flag);
	COV_CLEAR: cover property (@(posedge clock) disable iff (!rst_n)
		rd_pb_pin ##2 (port_change_flag && flag_clear) ##1 !port_change_flag);
	COV_PULLUP: cover property (@(posedge clock) disable iff (!rst_n) port_b_pullup != 8'h00);
	COV_CYCLE_CLOCK_OUT: cover property (@(posedge clock) disable iff (!rst_n)
		cycle_clock_out_mode && port_a_oe[`GPCIO_PA_CLK_BIT]);

endmodule // gpcio_port

// ==== gpcio_board.sv ====
/* Board model: the pin levels that both GPIO ports see.
   Assumes the bench gives the external drive on each clock edge. */
`timescale 1ns/1ps
module gpcio_board (
	input  wire logic       clock,
	input  wire logic [7:0] a_out,
	input  wire logic [7:0] a_oe,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe,
	input  wire logic [7:0] b_pu,
	input  wire logic [7:0] a_ext,
	input  wire logic [7:0] b_ext,
	input  wire logic [7:0] b_ext_en,
	output logic      [7:0] a_pin,
	output logic      [7:0] b_pin
);
	initial b_pin = 8'h00;
	// Floating port B pins without pull-up flip every cycle, so a stale level is never read by luck
	always @(posedge clock) begin
		a_pin <= (a_oe & a_out) | (~a_oe & a_ext);
		b_pin <= (b_oe & b_out) | (~b_oe & b_ext_en & b_ext)
			| (~b_oe & ~b_ext_en & (b_pu | ~b_pin));
	end
endmodule // gpcio_board

// ==== gpcio_port_tb.sv ====
/* Self-checking bench for the two-port GPIO block.
   Assumes the board model and the register port of the block. */
`timescale 1ns/1ps
`include "gpcio_params.svh"
module gpcio_port_tb;
	logic       clock     = 1'b0;
	logic       rst_n     = 1'b0;
	logic [3:0] reg_addr  = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic [7:0] a_ext     = 8'h00;
	logic [7:0] b_ext     = 8'h5A;
	logic [7:0] b_ext_en  = 8'hFF;
	logic [7:0] reg_rdata, a_out, a_oe, b_out, b_oe, b_pu, a_pin, b_pin, rv;
	logic       flag, wake;
	int         error_cnt = 0;
	int         compares  = 0;
	always #5 clock = ~clock;
	gpcio_port u_gpcio_port (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_a_in(a_pin), .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_pin),
		.port_b_out(b_out), .port_b_oe(b_oe), .port_b_pullup(b_pu),
		.port_change_flag(flag), .wake_request(wake));
	gpcio_board u_gpcio_board (.clock(clock), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
		.b_oe(b_oe), .b_pu(b_pu), .a_ext(a_ext), .b_ext(b_ext), .b_ext_en(b_ext_en),
		.a_pin(a_pin), .b_pin(b_pin));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk(rv, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic t_reset;
		rchk(`GPCIO_OFF_PA_DIR, 8'hEF);
		rchk(`GPCIO_OFF_PB_DIR, 8'hFF);
		rchk(`GPCIO_OFF_INTERRUPT_CONTROL_TWO, 8'h80);
		rchk(`GPCIO_OFF_PB_PIN, 8'h50);
		chk(b_pu, 8'h00);
		chk(b_oe, 8'h00);
		rchk(4'hF, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_dir;
		wr(`GPCIO_OFF_AN_HIGH, 8'hFF);
		wr(`GPCIO_OFF_PB_LAT, 8'hA5);
		wr(`GPCIO_OFF_PB_DIR, 8'h0F);
		idle(2);
		chk(b_oe, 8'hF0);
		chk(b_out & b_oe, 8'hA0);
		idle(3);
		rchk(`GPCIO_OFF_PB_PIN, 8'hAA);
		rchk(`GPCIO_OFF_PB_LAT, 8'hA5);
		$display("test direction done");
	endtask
	task automatic t_pull;
		wr(`GPCIO_OFF_PB_DIR, 8'h3F);
		wr(`GPCIO_OFF_AN_HIGH, 8'h03);
		wr(`GPCIO_OFF_INTERRUPT_CONTROL_TWO, 8'h00);
		idle(2);
		chk(b_pu, 8'h33);
		wr(`GPCIO_OFF_INTERRUPT_CONTROL_TWO, 8'h80);
		idle(2);
		chk(b_pu, 8'h00);
		$display("test pullup done");
	endtask
	task automatic t_change;
		wr(`GPCIO_OFF_PB_DIR, 8'hFF);
		wr(`GPCIO_OFF_AN_HIGH, 8'hFF);
		idle(3);
		rd(`GPCIO_OFF_PB_PIN);
		wr(`GPCIO_OFF_INTERRUPT_CONTROL, 8'h00);
		idle(2);
		chk({6'h0, wake, flag}, 8'h00);
		@(posedge clock) b_ext <= 8'h7A;
		idle(4);
		chk({6'h0, wake, flag}, 8'h03);
		wr(`GPCIO_OFF_INTERRUPT_CONTROL, 8'h00);
		idle(2);
		chk({7'h0, flag}, 8'h01);
		rd(`GPCIO_OFF_PB_PIN);
		wr(`GPCIO_OFF_INTERRUPT_CONTROL, 8'h00);
		idle(2);
		chk({7'h0, flag}, 8'h00);
		@(posedge clock) b_ext <= 8'h78;
		idle(4);
		chk({7'h0, flag}, 8'h00);
		wr(`GPCIO_OFF_PB_LAT, 8'h00);
		wr(`GPCIO_OFF_PB_DIR, 8'hBF);
		idle(4);
		chk({7'h0, flag}, 8'h00);
		$display("test change done");
	endtask
	task automatic t_port_a_pin_levels;
		logic [7:0] n;
		logic       prev;
		@(posedge clock) a_ext <= 8'h20;
		wr(`GPCIO_OFF_PA_LAT, 8'hFF);
		idle(3);
		rchk(`GPCIO_OFF_PA_PIN, 8'h00);
		rchk(`GPCIO_OFF_PA_LAT, 8'hEF);
		wr(`GPCIO_OFF_AN_LOW, 8'h10);
		idle(3);
		rchk(`GPCIO_OFF_PA_PIN, 8'h20);
		wr(`GPCIO_OFF_AN_LOW, 8'hE0);
		rchk(`GPCIO_OFF_AN_LOW, 8'hE0);
		wr(`GPCIO_OFF_AN_LOW, 8'h00);
		wr(`GPCIO_OFF_PA_DIR, 8'hDF);
		idle(2);
		chk({6'h0, a_oe[5], a_out[5]}, 8'h03);
		for (int m = 1; m < 3; m++) begin
			wr(`GPCIO_OFF_OSC_MODE, 8'(m));
			idle(3);
			n = 8'h00;
			repeat (8) begin
				prev = a_out[6];
				idle(1);
				if (a_out[6] !== prev) n++;
			end
			chk(n, 8'h04);
			chk({7'h0, a_oe[6]}, 8'h01);
		end
		wr(`GPCIO_OFF_OSC_MODE, 8'h00);
		idle(2);
		chk({7'h0, a_oe[6]}, 8'h00);
		$display("test port a done");
	endtask
	task automatic end_sim;
		$display("compares=%0d mismatches=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		idle(1);
		t_reset();
		t_dir();
		t_pull();
		t_change();
		t_port_a_pin_levels();
		end_sim();
	end
	// About 140 cycles expected; fourteen times that is a hang
	initial begin
		#20000;
		error_cnt++;
		end_sim();
	end
endmodule // gpcio_port_tb
